// ===== hw/spo_pnp_map.svh
// Purpose: constants for the plug-and-play owner and link information fields
// Assumes: field addresses are plug-and-play field indices, one 32-bit word each
// Notes: holds definitions only
// Functional notes
// - link info top byte shows initiator logical address of last owning swap
// - owner port field shows port that carried the last owning swap
// - return port field shows port on which this read's reply leaves
// - device type bit always reads one, marking a router
// - unit information valid bit reads zero after reset
// - nonzero write to unit vendor/product field sets unit valid bit
// - port count field always reads twelve in bits 4:0
// - owner word 0 holds reply bytes 0-3, zero without reply address
// - owner word 1 holds reply bytes 4-7 of owning swap
// - owner word 1 is zero when reply address is four bytes or less
// - owner word 2 holds reply bytes 8-11 of owning swap
// - owner word 2 is zero when reply address is eight bytes or less
// - device id changes only by swap; zero id or lost port means no owner
// - write or swap to these read-only fields answers read-only error status
`ifndef SPO_PNP_MAP_SVH
`define SPO_PNP_MAP_SVH
`define SPO_ADDR_LINK_INFO 32'h0000_0004
`define SPO_ADDR_OWNER_W0 32'h0000_0005
`define SPO_ADDR_OWNER_W1 32'h0000_0006
`define SPO_ADDR_OWNER_W2 32'h0000_0007
`define SPO_ADDR_DEVICE_ID 32'h0000_0008
`define SPO_ADDR_UNIT_VEND 32'h0000_0009
`define SPO_OLA_MSB 31
`define SPO_OLA_LSB 24
`define SPO_OAL_MSB 23
`define SPO_OAL_LSB 22
`define SPO_OL_MSB 20
`define SPO_OL_LSB 16
`define SPO_RL_MSB 12
`define SPO_RL_LSB 8
`define SPO_TYPE_BIT 7
`define SPO_UNIT_BIT 6
`define SPO_LC_MSB 4
`define SPO_LC_LSB 0
`define SPO_PORT_COUNT 5'h0C
`define SPO_STATUS_OK 8'h00
`define SPO_STATUS_READ_ONLY 8'hF2
`endif

// ===== hw/spo_pnp_pkg.sv
// Purpose: types for the plug-and-play owner and link information block
// Assumes: nothing
// Notes: constants live in spo_pnp_map.svh
package spo_pnp_pkg;
  typedef enum logic [1:0] {
    SPO_OP_READ = 2'b00,
    SPO_OP_WRITE = 2'b01,
    SPO_OP_CAS = 2'b10
  } spo_op_t;
endpackage

// ===== hw/spo_pnp_owner.sv
// Purpose: owner and link information fields of the router plug-and-play service
// Assumes: the packet parser presents one decoded access per REQ_VALID pulse
// Assumes: the parser alone decides when a swap has set the device identifier
// Notes: answer follows one cycle after the request
// Notes: owner fields survive a loss of ownership, only OWNED drops
// Notes: fields outside 4..7 give RSP_HIT low and are answered by upper logic
`timescale 1ns/1ns
`include "spo_pnp_map.svh"
`default_nettype none
module spo_pnp_owner
  import spo_pnp_pkg::*;
#(
  parameter int PORT_W = 5
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_OP,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [PORT_W-1:0] REQ_RETURN_PORT,
  input wire logic OWN_SET,
  input wire logic [7:0] OWN_INIT_ADDR,
  input wire logic [PORT_W-1:0] OWN_PORT,
  input wire logic [3:0] OWN_REPLY_LEN,
  input wire logic [95:0] OWN_REPLY_BYTES,
  input wire logic OWN_LOST,
  input wire logic UNIT_VEND_WR,
  input wire logic [31:0] UNIT_VEND_DATA,
  output logic RSP_VALID,
  output logic [31:0] RSP_DATA,
  output logic [7:0] RSP_STATUS,
  output logic RSP_HIT,
  output logic OWNED
);

  // stored owner state
  logic [7:0] ola_q, ola_d;
  logic [PORT_W-1:0] oport_q, oport_d;
  logic [1:0] owc_q, owc_d;
  logic [31:0] ow0_q, ow0_d;
  logic [31:0] ow1_q, ow1_d;
  logic [31:0] ow2_q, ow2_d;
  logic unit_q, unit_d;
  logic owned_q, owned_d;

  // response registers
  logic rv_q, rv_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] rstat_q, rstat_d;
  logic rhit_q, rhit_d;
  logic [31:0] link_word;

  // word i of the reply address, zero where the address is too short
  function automatic logic [31:0] reply_word(input logic [95:0] b, input logic [3:0] len,
                                             input int idx);
    logic [31:0] w;
    w = b[idx*32 +: 32];
    if (int'(len) <= idx * 4) begin
      w = 32'h0000_0000;
    end
    return w;
  endfunction

  // number of owner words that carry reply address data
  function automatic logic [1:0] word_count(input logic [3:0] len);
    logic [1:0] c;
    if (len == 4'h0) begin
      c = 2'h0;
    end else if (len <= 4'h4) begin
      c = 2'h1;
    end else if (len <= 4'h8) begin
      c = 2'h2;
    end else begin
      c = 2'h3;
    end
    return c;
  endfunction

  // true for the four fields kept in this block
  function automatic logic field_hit(input logic [31:0] addr);
    logic h;
    h = 1'b0;
    if (addr == `SPO_ADDR_LINK_INFO) begin
      h = 1'b1;
    end else if (addr == `SPO_ADDR_OWNER_W0) begin
      h = 1'b1;
    end else if (addr == `SPO_ADDR_OWNER_W1) begin
      h = 1'b1;
    end else if (addr == `SPO_ADDR_OWNER_W2) begin
      h = 1'b1;
    end
    return h;
  endfunction

  // owner logical address, latched by each owning swap
  always_comb begin
    ola_d = ola_q;
    if (OWN_SET) begin
      ola_d = OWN_INIT_ADDR;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ola_q <= 8'h00;
    end else begin
      ola_q <= ola_d;
    end
  end

  // port that carried the owning swap
  always_comb begin
    oport_d = oport_q;
    if (OWN_SET) begin
      oport_d = OWN_PORT;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      oport_q <= '0;
    end else begin
      oport_q <= oport_d;
    end
  end

  // how many owner words hold data
  always_comb begin
    owc_d = owc_q;
    if (OWN_SET) begin
      owc_d = word_count(OWN_REPLY_LEN);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      owc_q <= 2'h0;
    end else begin
      owc_q <= owc_d;
    end
  end

  // owner word 0, reply bytes 0-3
  always_comb begin
    ow0_d = ow0_q;
    if (OWN_SET) begin
      ow0_d = reply_word(OWN_REPLY_BYTES, OWN_REPLY_LEN, 0);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ow0_q <= 32'h0000_0000;
    end else begin
      ow0_q <= ow0_d;
    end
  end

  // owner word 1, reply bytes 4-7
  always_comb begin
    ow1_d = ow1_q;
    if (OWN_SET) begin
      ow1_d = reply_word(OWN_REPLY_BYTES, OWN_REPLY_LEN, 1);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ow1_q <= 32'h0000_0000;
    end else begin
      ow1_q <= ow1_d;
    end
  end

  // owner word 2, reply bytes 8-11
  always_comb begin
    ow2_d = ow2_q;
    if (OWN_SET) begin
      ow2_d = reply_word(OWN_REPLY_BYTES, OWN_REPLY_LEN, 2);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ow2_q <= 32'h0000_0000;
    end else begin
      ow2_q <= ow2_d;
    end
  end

  // ownership flag; a new owner outranks a loss in the same cycle
  always_comb begin
    owned_d = owned_q;
    if (OWN_SET) begin
      owned_d = 1'b1;
    end else if (OWN_LOST) begin
      owned_d = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      owned_q <= 1'b0;
    end else begin
      owned_q <= owned_d;
    end
  end

  // unit information valid; set only, cleared by reset alone
  always_comb begin
    unit_d = unit_q;
    if (UNIT_VEND_WR && (UNIT_VEND_DATA != 32'h0000_0000)) begin
      unit_d = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      unit_q <= 1'b0;
    end else begin
      unit_q <= unit_d;
    end
  end

  // link information word as a read sees it
  always_comb begin
    link_word = 32'h0000_0000;
    link_word[`SPO_OLA_MSB:`SPO_OLA_LSB] = ola_q;
    link_word[`SPO_OAL_MSB:`SPO_OAL_LSB] = owc_q;
    link_word[`SPO_OL_MSB:`SPO_OL_LSB] = oport_q;
    link_word[`SPO_RL_MSB:`SPO_RL_LSB] = REQ_RETURN_PORT;
    link_word[`SPO_TYPE_BIT] = 1'b1;
    link_word[`SPO_UNIT_BIT] = unit_q;
    link_word[`SPO_LC_MSB:`SPO_LC_LSB] = `SPO_PORT_COUNT;
  end

  // answer strobe, one cycle after each request
  always_comb begin
    rv_d = REQ_VALID;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rv_q <= 1'b0;
    end else begin
      rv_q <= rv_d;
    end
  end

  // hit flag, so upper logic can answer the fields not kept here
  always_comb begin
    rhit_d = REQ_VALID && field_hit(REQ_ADDR);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rhit_q <= 1'b0;
    end else begin
      rhit_q <= rhit_d;
    end
  end

  // writes and swaps to these fields are refused
  always_comb begin
    rstat_d = `SPO_STATUS_OK;
    if (REQ_VALID && field_hit(REQ_ADDR) && (REQ_OP != SPO_OP_READ)) begin
      rstat_d = `SPO_STATUS_READ_ONLY;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rstat_q <= 8'h00;
    end else begin
      rstat_q <= rstat_d;
    end
  end

  // read data; zero on refusal and for fields not kept here
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (REQ_VALID && (REQ_OP == SPO_OP_READ)) begin
      if (REQ_ADDR == `SPO_ADDR_LINK_INFO) begin
        rdata_d = link_word;
      end else if (REQ_ADDR == `SPO_ADDR_OWNER_W0) begin
        rdata_d = ow0_q;
      end else if (REQ_ADDR == `SPO_ADDR_OWNER_W1) begin
        rdata_d = ow1_q;
      end else if (REQ_ADDR == `SPO_ADDR_OWNER_W2) begin
        rdata_d = ow2_q;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign RSP_VALID = rv_q;
  assign RSP_DATA = rdata_q;
  assign RSP_STATUS = rstat_q;
  assign RSP_HIT = rhit_q;
  assign OWNED = owned_q;

endmodule // spo_pnp_owner
`default_nettype wire

// ===== bench/spo_init_model.sv
// Purpose: far-side initiator fields
// Assumes: whole-word reply lengths
// Notes: bytes past the length stay junk
`timescale 1ns/1ns
`default_nettype none
module spo_init_model (
  input wire logic [1:0] sel,
  input wire logic [95:0] raw,
  output logic [3:0] len,
  output logic [95:0] bytes
);
  assign len = {sel, 2'h0};
  assign bytes = raw;
endmodule // spo_init_model
`default_nettype wire

// ===== bench/spo_owner_monitor.sv
// Purpose: port checks
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ns
`default_nettype none
module spo_owner_monitor #(parameter int PORT_W = 5) (
  input wire logic CLK, RST_N, REQ_VALID, OWN_SET, UNIT_VEND_WR, RSP_VALID, RSP_HIT, OWNED,
  input wire logic [1:0] REQ_OP,
  input wire logic [31:0] REQ_ADDR, UNIT_VEND_DATA, RSP_DATA,
  input wire logic [PORT_W-1:0] REQ_RETURN_PORT,
  input wire logic [7:0] RSP_STATUS
);
  wire logic hit = REQ_ADDR inside {[32'h4:32'h7]};
  wire logic rd4 = REQ_VALID && REQ_OP == 2'h0 && REQ_ADDR == 32'h4;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_a; REQ_VALID |=> RSP_VALID; endproperty
  a_a: assert property (p_a) else $error("a");
  property p_b; !REQ_VALID |=> !RSP_VALID && RSP_DATA == 32'h0; endproperty
  a_b: assert property (p_b) else $error("b");
  property p_c; rd4 |=> RSP_DATA[7] && RSP_DATA[4:0] == 5'h0C; endproperty
  a_c: assert property (p_c) else $error("c");
  property p_d; rd4 |=> RSP_DATA[12:8] == $past(REQ_RETURN_PORT); endproperty
  a_d: assert property (p_d) else $error("d");
  property p_e; REQ_VALID && hit && REQ_OP != 2'h0 |=> RSP_STATUS == 8'hF2; endproperty
  a_e: assert property (p_e) else $error("e");
  property p_f; REQ_VALID |=> RSP_HIT == $past(hit); endproperty
  a_f: assert property (p_f) else $error("f");
  property p_g; UNIT_VEND_WR && UNIT_VEND_DATA != 32'h0 ##1 rd4 |=> RSP_DATA[6]; endproperty
  a_g: assert property (p_g) else $error("g");
  property p_h; OWN_SET |=> OWNED; endproperty
  a_h: assert property (p_h) else $error("h");
  c_a: cover property (OWN_SET ##1 rd4);
  c_b: cover property (REQ_VALID && hit && REQ_OP == 2'h2);
  c_c: cover property (UNIT_VEND_WR ##1 rd4);
endmodule // spo_owner_monitor
bind spo_pnp_owner spo_owner_monitor #(.PORT_W(PORT_W)) u_mon (.CLK, .RST_N, .REQ_VALID,
  .OWN_SET, .UNIT_VEND_WR, .RSP_VALID, .RSP_HIT, .OWNED, .REQ_OP, .REQ_ADDR,
  .UNIT_VEND_DATA, .RSP_DATA, .REQ_RETURN_PORT, .RSP_STATUS);
`default_nettype wire

// ===== bench/tb_spo_pnp_owner.sv
// Purpose: random bench
// Assumes: falling-edge drive
// Notes: integer model
`timescale 1ns/1ns
`default_nettype none
module tb_spo_pnp_owner;
  logic CLK = 0, RST_N = 0, REQ_VALID = 0, OWN_SET = 0, OWN_LOST = 0, UNIT_VEND_WR = 0;
  logic RSP_VALID, RSP_HIT, OWNED, h;
  logic [1:0] REQ_OP = 0;
  logic [4:0] REQ_RETURN_PORT = 0, OWN_PORT = 0;
  logic [7:0] OWN_INIT_ADDR = 0, RSP_STATUS;
  logic [3:0] OWN_REPLY_LEN;
  logic [31:0] REQ_ADDR = 0, UNIT_VEND_DATA = 0, RSP_DATA;
  logic [95:0] OWN_REPLY_BYTES, raw = 0, ra = 0;
  logic [63:0] r = 0;
  logic [42:0] e = 0;
  int seed = 32'h2AEFC75D, fail_count = 0, cmp_count = 0;
  int owner_logical_addr = 0, ol = 0, len = 0, unit = 0, own = 0;
  always #50 CLK = ~CLK;
  spo_init_model u_init (.sel(r[33:32]), .raw, .len(OWN_REPLY_LEN), .bytes(OWN_REPLY_BYTES));
  spo_pnp_owner dut (.CLK, .RST_N, .REQ_VALID, .REQ_OP, .REQ_ADDR, .REQ_RETURN_PORT,
    .OWN_SET, .OWN_INIT_ADDR, .OWN_PORT, .OWN_REPLY_LEN, .OWN_REPLY_BYTES, .OWN_LOST,
    .UNIT_VEND_WR, .UNIT_VEND_DATA, .RSP_VALID, .RSP_DATA, .RSP_STATUS, .RSP_HIT, .OWNED);
  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input logic [42:0] g, x);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  function automatic logic [31:0] rd(int a);
    if (a != 4) return ra[32*(a-5)+:32];
    return {owner_logical_addr[7:0], 2'((len + 3) / 4), 1'h0, ol[4:0], 3'h0, REQ_RETURN_PORT,
      1'h1, unit[0], 1'h0, 5'h0C};
  endfunction
  initial begin
    repeat (6) @(negedge CLK);
    RST_N = 1;
    repeat (400) begin
      @(negedge CLK);
      cmp({RSP_VALID, RSP_HIT, RSP_STATUS, RSP_DATA, OWNED}, e);
      r = {$random(seed), $random(seed)};
      raw = {$random(seed), $random(seed), $random(seed)};
      {REQ_VALID, REQ_RETURN_PORT, OWN_INIT_ADDR, OWN_PORT} = r[18:0];
      REQ_OP = 2'(r[20:19] % 2'h3);
      REQ_ADDR = 32'h3 + 32'(r[23:21] % 3'h6);
      OWN_SET = &r[25:24];
      OWN_LOST = &r[28:26];
      UNIT_VEND_WR = &r[30:29];
      UNIT_VEND_DATA = r[31] ? 32'(r[63:34]) : 32'h0;
      #1;
      h = REQ_ADDR inside {[4:7]};
      e = {REQ_VALID, REQ_VALID & h, 41'h0};
      if (e[41] && REQ_OP != 2'h0) e[40:33] = 8'hF2;
      else if (e[41]) e[32:1] = rd(REQ_ADDR);
      if (OWN_SET) begin
        owner_logical_addr = OWN_INIT_ADDR;
        ol = OWN_PORT;
        len = OWN_REPLY_LEN;
        ra = OWN_REPLY_BYTES;
        for (int w = 0; w < 3; w++) if (len <= 4 * w) ra[32*w+:32] = 32'h0;
      end
      if (UNIT_VEND_WR && UNIT_VEND_DATA != 32'h0) unit = 1;
      own = OWN_SET ? 1 : OWN_LOST ? 0 : own;
      e[0] = own[0];
    end
    $display("test random_traffic done");
    conclude();
  end
  initial begin
    #100000;
    fail_count++;
    conclude();
  end
endmodule // tb_spo_pnp_owner
`default_nettype wire
